/* src/sdmc_pkg.sv */
// constants and types for the serial converter mode control block
// Notes on behaviour
// - mode 00 selects normal amplifier-driven output
// - nonzero mode powers down; 01 1k, 10 100k
// - mode 11 leaves output open-circuit
// - power-down keeps the stored code; frames sent in power-down still load new code
// - power-down shuts bias, amplifier, string off
// - output flagged unsettled 4 us after wake
// - 24-bit frame, acted on at 24th fall
// - data sampled on falling clock while selected
// - early frame-select rise discards the frame
// - mode bits sit at frame bits 17, 16
package sdmc_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS    = 24;
  localparam int unsigned DATA_BITS     = 16;
  localparam int unsigned MODE_BIT_HIGH = 17;
  localparam int unsigned MODE_BIT_LOW  = 16;
  localparam int unsigned CNT_W         = 5;

  // ----------------------------------------------------------------
  // mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_NORMAL   = 2'h0;
  localparam logic [1:0]  MODE_PD_1K    = 2'h1;
  localparam logic [1:0]  MODE_PD_100K  = 2'h2;
  localparam logic [1:0]  MODE_PD_OPEN  = 2'h3;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam logic [15:0] CODE_RST      = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned WAKE_TIME_US  = 4;
  localparam int unsigned WAKE_CYCLES   =
    (WAKE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_W        = 10;

  typedef enum logic [2:0] {
    SDMC_IDLE  = 3'b001,
    SDMC_SHIFT = 3'b010,
    SDMC_DONE  = 3'b100
  } sdmc_state_t;

endpackage
`default_nettype wire

/* src/sdmc_if.sv */
// link from the frame receiver to the mode control core
`timescale 1ns/1ps
`default_nettype none
interface sdmc_if;
  logic        frame_valid;
  logic [1:0]  frame_mode;
  logic [15:0] frame_code;

  modport rx   (output frame_valid, output frame_mode, output frame_code);
  modport core (input frame_valid, input frame_mode, input frame_code);
endinterface
`default_nettype wire

/* src/sdmc_frame_rx.sv */
// serial frame receiver: synchronises pins and assembles 24-bit frames
`timescale 1ns/1ps
`default_nettype none
module sdmc_frame_rx
  import sdmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic sclk,
  input  wire logic sync_n,
  input  wire logic sdin,
  sdmc_if.rx        frm
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] meta_ff;
  logic [2:0] sync2_ff;
  logic       sclk_prev_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // link clock idles low, so no false fall appears after reset
      meta_ff      <= 3'h3;
      sync2_ff     <= 3'h3;
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff      <= {sclk, sync_n, sdin};
      sync2_ff     <= meta_ff;
      sclk_prev_ff <= sync2_ff[2];
    end
  end

  logic sclk_s;
  logic sync_n_s;
  logic sdin_s;
  logic sclk_fall;

  assign sclk_s    = sync2_ff[2];
  assign sync_n_s  = sync2_ff[1];
  assign sdin_s    = sync2_ff[0];
  assign sclk_fall = sclk_prev_ff & ~sclk_s;

  // ----------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------
  sdmc_state_t             state_ff;
  logic [FRAME_BITS-1:0]   shift_ff;
  logic [CNT_W-1:0]        count_ff;
  logic                    valid_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= SDMC_IDLE;
      shift_ff <= '0;
      count_ff <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= 1'b0;
      case (state_ff)
        SDMC_IDLE:
        begin
          shift_ff <= '0;
          count_ff <= '0;
          if (!sync_n_s)
            state_ff <= SDMC_SHIFT;
        end
        SDMC_SHIFT:
        begin
          if (sync_n_s)
          begin
            // early rise: frame dropped, nothing applied
            shift_ff <= '0;
            count_ff <= '0;
            state_ff <= SDMC_IDLE;
          end
          else if (sclk_fall)
          begin
            shift_ff <= {shift_ff[FRAME_BITS-2:0], sdin_s};
            if (count_ff == CNT_W'(FRAME_BITS - 1))
            begin
              valid_ff <= 1'b1;
              state_ff <= SDMC_DONE;
            end
            count_ff <= count_ff + 1'b1;
          end
        end
        SDMC_DONE:
        begin
          // further clocks ignored until frame-select rises again
          if (sync_n_s)
            state_ff <= SDMC_IDLE;
        end
        default:
          state_ff <= SDMC_IDLE;
      endcase
    end
  end

  assign frm.frame_valid = valid_ff;
  assign frm.frame_mode  = shift_ff[MODE_BIT_HIGH:MODE_BIT_LOW];
  assign frm.frame_code  = shift_ff[DATA_BITS-1:0];

endmodule // sdmc_frame_rx
`default_nettype wire

/* src/sdmc_top.sv */
// serial converter mode control: stored code, power-down mode, wake timer
`timescale 1ns/1ps
`default_nettype none
module sdmc_top
  import sdmc_pkg::*;
#(
  parameter logic [15:0] CODE_RESET = CODE_RST
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        sdin,
  output logic [15:0]      dac_code,
  output logic [1:0]       op_mode,
  output logic             amp_drive,
  output logic             analog_on,
  output logic             pd_load_1k,
  output logic             pd_load_100k,
  output logic             out_open,
  output logic             out_settled
);

  sdmc_if frm ();

  sdmc_frame_rx u_rx (
    .clk    (clk),
    .resetn (resetn),
    .sclk   (sclk),
    .sync_n (sync_n),
    .sdin   (sdin),
    .frm    (frm)
  );

  // ----------------------------------------------------------------
  // code and mode registers
  // ----------------------------------------------------------------
  logic [15:0] code_ff;
  logic [1:0]  mode_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      code_ff <= CODE_RESET;
      mode_ff <= MODE_RST;
    end
    else if (frm.frame_valid)
    begin
      // code loads in every mode so it is ready at wake-up
      code_ff <= frm.frame_code;
      mode_ff <= frm.frame_mode;
    end
  end

  // ----------------------------------------------------------------
  // output stage decode
  // ----------------------------------------------------------------
  logic        amp_ff;
  logic        on_ff;
  logic        l1k_ff;
  logic        l100k_ff;
  logic        open_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      amp_ff   <= 1'b1;
      on_ff    <= 1'b1;
      l1k_ff   <= 1'b0;
      l100k_ff <= 1'b0;
      open_ff  <= 1'b0;
    end
    else
    begin
      amp_ff   <= (mode_ff == MODE_NORMAL);
      on_ff    <= (mode_ff == MODE_NORMAL);
      l1k_ff   <= (mode_ff == MODE_PD_1K);
      l100k_ff <= (mode_ff == MODE_PD_100K);
      open_ff  <= (mode_ff == MODE_PD_OPEN);
    end
  end

  // ----------------------------------------------------------------
  // wake-up settling timer
  // ----------------------------------------------------------------
  logic [WAKE_W-1:0] wake_cnt_ff;
  logic              settled_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_cnt_ff <= '0;
      settled_ff  <= 1'b1;
    end
    else if (frm.frame_valid && mode_ff != MODE_NORMAL
             && frm.frame_mode == MODE_NORMAL)
    begin
      wake_cnt_ff <= WAKE_W'(WAKE_CYCLES);
      settled_ff  <= 1'b0;
    end
    else if (frm.frame_valid && frm.frame_mode != MODE_NORMAL)
    begin
      wake_cnt_ff <= '0;
      settled_ff  <= 1'b0;
    end
    else if (wake_cnt_ff > WAKE_W'(1))
      wake_cnt_ff <= wake_cnt_ff - 1'b1;
    else if (wake_cnt_ff == WAKE_W'(1))
    begin
      wake_cnt_ff <= '0;
      settled_ff  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // code register is untouched by mode, so it stays visible in power-down
  assign dac_code     = code_ff;
  assign op_mode      = mode_ff;
  assign amp_drive    = amp_ff;
  assign analog_on    = on_ff;
  assign pd_load_1k   = l1k_ff;
  assign pd_load_100k = l100k_ff;
  assign out_open     = open_ff;
  assign out_settled  = settled_ff;

endmodule // sdmc_top
`default_nettype wire

/* tb/sdmc_properties.sv */
// assertion checker for the serial converter mode control block
`timescale 1ns/1ps
`default_nettype none
module sdmc_properties
  import sdmc_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        sync_n,
  input wire logic [15:0] dac_code,
  input wire logic [1:0]  op_mode,
  input wire logic        amp_drive,
  input wire logic        analog_on,
  input wire logic        pd_load_1k,
  input wire logic        pd_load_100k,
  input wire logic        out_open,
  input wire logic        out_settled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [9:0] wake_ff;
  // cycles spent unsettled while the amplifier already drives
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) wake_ff <= 10'h0;
    else wake_ff <= (amp_drive && !out_settled) ? wake_ff + 10'h1 : 10'h0;
  sequence s_low8; !out_settled [*8]; endsequence
  property p_normal; $past(op_mode) == MODE_NORMAL |-> amp_drive && analog_on; endproperty
  property p_pd_1k; $past(op_mode) == MODE_PD_1K |-> pd_load_1k && !analog_on; endproperty
  property p_pd_100k; $past(op_mode) == MODE_PD_100K |-> pd_load_100k && !out_settled; endproperty
  property p_pd_open; $past(op_mode) == MODE_PD_OPEN |-> out_open && !amp_drive; endproperty
  property p_onehot; $onehot({amp_drive, pd_load_1k, pd_load_100k, out_open}); endproperty
  property p_frame; $changed(op_mode) || $changed(dac_code) |-> $past(sync_n, 5) == 1'b0;
  endproperty
  property p_wake_low; $rose(amp_drive) |-> s_low8; endproperty
  property p_wake_len; $rose(out_settled) |-> wake_ff inside {[10'd498:10'd502]}; endproperty
  a_normal: assert property (p_normal) else $error("normal mode outputs wrong");
  a_pd_1k: assert property (p_pd_1k) else $error("1k power-down wrong");
  a_pd_100k: assert property (p_pd_100k) else $error("100k power-down wrong");
  a_pd_open: assert property (p_pd_open) else $error("open output wrong");
  a_onehot: assert property (p_onehot) else $error("output stage not one-hot");
  a_frame: assert property (p_frame) else $error("state changed outside frame");
  a_wake_low: assert property (p_wake_low) else $error("settled too early");
  a_wake_len: assert property (p_wake_len) else $error("wake time wrong");
endmodule // sdmc_properties
bind sdmc_top sdmc_properties sdmc_properties_inst (.clk(clk), .resetn(resetn),
  .sync_n(sync_n), .dac_code(dac_code), .op_mode(op_mode), .amp_drive(amp_drive),
  .analog_on(analog_on), .pd_load_1k(pd_load_1k), .pd_load_100k(pd_load_100k),
  .out_open(out_open), .out_settled(out_settled));
`default_nettype wire

/* tb/sdmc_host.sv */
// host model driving frames on the three-wire link
`timescale 1ns/1ps
`default_nettype none
module sdmc_host
(
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  initial
  begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdin = 1'b1;
  end
  // n below 24 cuts the frame short; sclk rests low between frames
  task automatic send(input logic [23:0] f, input int n);
    sync_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      sdin = f[23 - i];
      #62.5;
      sclk = 1'b0;
      #62.5;
    end
    // line moves only after a fall, never across one
    sdin = ~sdin;
    sync_n = 1'b1;
    #250;
  endtask
endmodule // sdmc_host
`default_nettype wire

/* tb/tb_sdmc_top.sv */
// self-checking bench for the serial converter mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_sdmc_top;
  import sdmc_pkg::*;
  logic        clk;
  logic        resetn;
  wire logic   sclk;
  wire logic   sync_n;
  wire logic   sdin;
  logic [15:0] dac_code;
  logic [1:0]  op_mode;
  logic        amp_drive, analog_on, pd_load_1k, pd_load_100k, out_open, out_settled;
  int          error_cnt;
  int          n_tests;
  int          cyc;
  initial clk = 1'b0;
  always #4 clk = ~clk;
  sdmc_host sdmc_host_inst (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  sdmc_top sdmc_top_inst (.clk(clk), .resetn(resetn), .sclk(sclk), .sync_n(sync_n),
    .sdin(sdin), .dac_code(dac_code), .op_mode(op_mode), .amp_drive(amp_drive),
    .analog_on(analog_on), .pd_load_1k(pd_load_1k), .pd_load_100k(pd_load_100k),
    .out_open(out_open), .out_settled(out_settled));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [6:0] exp_st(input logic [1:0] m);
    return {m, m == 2'h0, m == 2'h0, m == 2'h1, m == 2'h2, m == 2'h3};
  endfunction
  task automatic t_reset();
    chk({dac_code, op_mode, out_settled}, {CODE_RST, MODE_RST, 1'b1});
  endtask
  // ignored bits set to ones; every power-down code, then wake
  task automatic t_modes();
    logic [1:0] m;
    for (int k = 1; k < 5; k++)
    begin
      m = k[1:0];
      sdmc_host_inst.send({6'h3f, m, 16'h1230 + k[15:0]}, 24);
      chk({dac_code, op_mode, amp_drive, analog_on, pd_load_1k, pd_load_100k, out_open},
        {16'h1230 + k[15:0], exp_st(m)});
      chk(out_settled, 1'b0);
    end
    wait_clk(440);
    chk({dac_code, out_settled}, {16'h1234, 1'b0});
    wait_clk(60);
    chk(out_settled, 1'b1);
  endtask
  // a frame cut at 23 bits must change nothing
  task automatic t_abort();
    sdmc_host_inst.send({6'h00, 2'h1, 16'hbeef}, 23);
    chk({dac_code, op_mode, out_settled}, {16'h1234, 2'h0, 1'b1});
    sdmc_host_inst.send({6'h00, 2'h0, 16'hffff}, 24);
    chk({dac_code, op_mode, out_settled}, {16'hffff, 2'h0, 1'b1});
  endtask
  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    resetn = 1'b0;
    wait_clk(12);
    resetn = 1'b1;
    wait_clk(3);
    t_reset();
    t_modes();
    t_abort();
    resetn = 1'b0;
    wait_clk(12);
    t_reset();
    resetn = 1'b1;
    wait_clk(3);
    test_done();
  end
endmodule // tb_sdmc_top
`default_nettype wire
